// ### bench/mprs_host_model.sv
// Host board model driving the two open-drain shutdown lines.
`default_nettype none
module mprs_host_model (
    input  wire logic       sys_clk,
    input  wire logic       restart,
    input  wire logic [1:0] off_req,
    output logic [1:0]      line_n
);
    timeunit 1ns;
    timeprecision 1ns;
    int hold_cnt = 0;
    // The restart hold is counted out in full before both lines are let go.
    always @(posedge sys_clk) hold_cnt <= restart ? 20 : hold_cnt - (hold_cnt > 0);
    // Lines are only pulled low or released to their pull-ups.
    assign line_n = (hold_cnt > 0) ? 2'h0 : ~off_req;
endmodule : mprs_host_model
`default_nettype wire

// ### bench/mprs_seq_props.sv
// Port checks for the card power and reset sequencer.
`default_nettype none
module mprs_seq_props
    import mprs_pkg::*;
(
    // Clock, reset and inputs.
    input wire logic         sys_clk, nrst, clk_en, init_done, wake_request, led_on_request,
    input wire mprs_ctl_type ctl,
    // Watched outputs.
    input wire logic         host_access_ok, radio_enable, core_reset_n, wake_host_o,
    input wire logic         wake_host_oe, status_led_drive_n_o, status_led_drive_n_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // A low line or a lost supply drops access, core reset and both pin enables at the next edge.
    a_shutdown_off: assert property (clk_en && ctl != 3'h7 |=> !(host_access_ok |
        core_reset_n | wake_host_oe | status_led_drive_n_oe)) else $error("output on in shutdown");
    a_self_start: assert property
        (clk_en && ctl == 3'h7 && !core_reset_n |-> ##[1:2] core_reset_n) else $error("no restart");
    a_init_gate: assert property ($rose(host_access_ok) |-> $past(init_done))
        else $error("access before init");
    // Access needs the core to have left reset at least 40 cycles before it is granted.
    a_activate_late: assert property ($rose(host_access_ok) |-> $past(core_reset_n, 40))
        else $error("access too early");
    a_radio_match: assert property (radio_enable == host_access_ok) else $error("radio");
    a_pins_low: assert property (!(wake_host_o | status_led_drive_n_o))
        else $error("open drain drove high");
    a_wake_pull: assert property
        (clk_en && ctl == 3'h7 && host_access_ok && wake_request |=> wake_host_oe) else $error("wake");
    a_led_pull: assert property
        (clk_en && ctl == 3'h7 && host_access_ok && led_on_request |=> status_led_drive_n_oe)
        else $error("led");
endmodule : mprs_seq_props
bind mprs_sequencer mprs_seq_props u_mprs_seq_props (.*);
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the card power and reset sequencer.
`default_nettype none
module tb_top;
    import mprs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(s, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %0h got %0h", s, e, g); end end
    logic sys_clk = 0, nrst = 0, clk_en = 1, init_done = 0, restart = 0, wake_request = 0;
    logic led_on_request = 0, host_access_ok, radio_enable, core_reset_n, wake_host_o;
    logic wake_host_oe, status_led_drive_n_o, status_led_drive_n_oe;
    logic [1:0] off_req = 0, line_n;
    mprs_ctl_type ctl;
    int error_cnt = 0, comparisons = 0, n;
    assign ctl = {line_n, 1'h1};
    mprs_host_model u_mprs_host_model (.*);
    mprs_sequencer #(.SUPPLY_CYCLES(4), .ACTIVATE_CYCLES(50)) u_mprs_sequencer (.*);
    initial forever #50 sys_clk = ~sys_clk;
    task cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #5;
    endtask : cyc
    // Bounded wait for host access; n keeps the cycles taken.
    task wait_acc;
        for (n = 0; host_access_ok !== 1'h1 && n < 200; n++) cyc(1);
    endtask : wait_acc
    task t_power;
        cyc(80);
        `CHK("access", 1'h0, host_access_ok)
        `CHK("core run", 1'h1, core_reset_n)
        {init_done, wake_request, led_on_request} = 3'h7;
        wait_acc();
        cyc(2);
        `CHK("pins", 4'ha, {wake_host_oe, wake_host_o, status_led_drive_n_oe, status_led_drive_n_o})
        `CHK("radio", 1'h1, radio_enable)
        clk_en = 0;
        off_req = 2'h3;
        cyc(2);
        `CHK("frozen", 2'h3, {host_access_ok, core_reset_n})
        off_req = 2'h0;
        cyc(1);
        clk_en = 1;
        cyc(1);
        {wake_request, led_on_request} = 2'h0;
        cyc(2);
        `CHK("pins off", 2'h0, {wake_host_oe, status_led_drive_n_oe})
        $display("t_power done");
    endtask : t_power
    // Shutdown by one line or a full restart hold, then timed recovery.
    task t_off(input logic [1:0] req, input logic rs);
        {off_req, restart} = {req, rs};
        cyc(3);
        `CHK("off", 3'h0, {host_access_ok, radio_enable, core_reset_n})
        {off_req, restart} = 3'h0;
        cyc(rs ? 21 : 1);
        `CHK("restart", 1'h1, core_reset_n)
        wait_acc();
        `CHK("delay", 1'h1, n > 44 && n < 53)
        $display("t_off done");
    endtask : t_off
    task summarize;
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize
    initial begin
        cyc(12);
        nrst = 1;
        t_power();
        t_off(2'h2, 0);
        t_off(2'h1, 0);
        t_off(2'h0, 1);
        summarize();
    end
    initial begin
        repeat (1000) @(posedge sys_clk);
        error_cnt++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire

// ### rtl/mprs_defs.svh
// Constants for the card power and reset sequencer.
`ifndef MPRS_DEFS_SVH
`define MPRS_DEFS_SVH
`define MPRS_CLK_HZ         10000000
`define MPRS_ACTIVATE_S     20
`define MPRS_ACTIVATE_CYC   (`MPRS_ACTIVATE_S * `MPRS_CLK_HZ)
`define MPRS_SUPPLY_MS      1
`define MPRS_SUPPLY_CYC     ((`MPRS_SUPPLY_MS * `MPRS_CLK_HZ) / 1000)
`endif

// ### rtl/mprs_pkg.sv
// Types shared by the card power and reset sequencer.
`default_nettype none
package mprs_pkg;
    typedef enum logic [1:0] {
        MPRS_OFF  = 2'b00,
        MPRS_PWRUP = 2'b01,
        MPRS_INIT = 2'b11,
        MPRS_ACTIVE = 2'b10
    } mprs_state_type;

    typedef struct packed {
        logic radio_off_n;
        logic card_reset_shutdown_n;
        logic supply_good;
    } mprs_ctl_type;
endpackage : mprs_pkg
`default_nettype wire

// ### rtl/mprs_sequencer.sv
// Power-on, shutdown and restart sequencer with wake and status LED outputs.
`include "mprs_defs.svh"
`default_nettype none

// How the sequencer behaves, in short.
// The card starts by itself once the supply is good and both shutdown lines are released.
// No power-on pulse is needed from the host.
// A short power-up phase lets the rails settle; the core leaves reset as that phase begins.
// The card then waits in initialization until two things hold.
// The activation count must have run out, and the card software must report that it is done.
// Only then does the host see access granted.
// A low on either shutdown line, or a lost supply, sends the card straight back to off.
// This happens from any state and in the very next cycle.
// Once both lines are released again, the card restarts by itself from off.
// The activation count starts again from zero, so every restart waits the full time.
// The host is expected to prepare the card with a halt command before pulling a line low.
// The sequencer cannot tell whether that was done, so it never delays a shutdown.
// A delayed shutdown would hide a stuck card from the emergency recovery path.
// The wake and status LED pins are open drain.
// They are only ever pulled low, and only while the card is active.
// While the card is off every pin is released, so nothing back-powers the host board.
// Limitation: the activation count is long at the real clock rate.
// Benches should shorten it through the parameters rather than wait twenty seconds.
// All outputs come straight from flip-flops, so they change one edge after the inputs.
// The clock enable freezes every register, outputs included, while it is low.
module mprs_sequencer
    import mprs_pkg::*;
#(
    parameter int unsigned SUPPLY_CYCLES   = `MPRS_SUPPLY_CYC,
    parameter int unsigned ACTIVATE_CYCLES = `MPRS_ACTIVATE_CYC
)
(
    // Clock, reset and clock enable.
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    input  wire logic         clk_en,
    // Shutdown inputs and supply status.
    input  wire mprs_ctl_type ctl,
    // Internal requests from the card software.
    input  wire logic         init_done,
    input  wire logic         wake_request,
    input  wire logic         led_on_request,
    // Status towards the rest of the card.
    output logic              host_access_ok,
    output logic              radio_enable,
    output logic              core_reset_n,
    // Open-drain pins, enable high while pulling low.
    output logic              wake_host_o,
    output logic              wake_host_oe,
    output logic              status_led_drive_n_o,
    output logic              status_led_drive_n_oe
);
    localparam int CW = $clog2(ACTIVATE_CYCLES + 1);

    mprs_state_type state_reg;
    mprs_state_type state_next;
    logic [CW-1:0]  count_reg;
    logic           shutdown_req;
    logic           count_done_pwr;
    logic           count_done_act;
    logic           going_active;
    logic           going_off;

    // Either line low is an unconditional shutdown request.
    assign shutdown_req = !ctl.radio_off_n || !ctl.card_reset_shutdown_n
                          || !ctl.supply_good;
    assign count_done_pwr = (count_reg >= CW'(SUPPLY_CYCLES - 1));
    assign count_done_act = (count_reg >= CW'(ACTIVATE_CYCLES - 1));

    // Next state; shutdown wins from any state, release restarts by itself.
    always_comb
    begin
        state_next = state_reg;
        if (shutdown_req)
        begin
            state_next = MPRS_OFF;
        end
        else
        begin
            unique case (state_reg)
                MPRS_OFF:    state_next = MPRS_PWRUP;
                MPRS_PWRUP:  if (count_done_pwr) state_next = MPRS_INIT;
                MPRS_INIT:   if (count_done_act && init_done) state_next = MPRS_ACTIVE;
                MPRS_ACTIVE: state_next = MPRS_ACTIVE;
            endcase
        end
    end

    // State register.
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            state_reg <= MPRS_OFF;
        else if (clk_en)
            state_reg <= state_next;
    end

    // Cycles since power-up began; the 20 s floor counts from supply and release.
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            count_reg <= '0;
        else if (clk_en)
        begin
            if (state_next == MPRS_OFF)
                count_reg <= '0;
            else if (!count_done_act)
                count_reg <= count_reg + CW'(1);
        end
    end

    // Outputs follow the next state, so they change on the same edge as the state.
    assign going_active = (state_next == MPRS_ACTIVE);
    assign going_off    = (state_next == MPRS_OFF);

    // Host access gate; stays closed through power-up and initialization.
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            host_access_ok <= 1'b0;
        end
        else if (clk_en)
        begin
            host_access_ok <= going_active;
        end
    end

    // Radio runs only when active and the radio-off line is released.
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            radio_enable <= 1'b0;
        end
        else if (clk_en)
        begin
            radio_enable <= going_active && ctl.radio_off_n;
        end
    end

    // Core reset is held while off; release restarts the card by itself.
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            core_reset_n <= 1'b0;
        end
        else if (clk_en)
        begin
            core_reset_n <= !going_off;
        end
    end

    // Open-drain wake pin only ever drives low, so its data stays zero.
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            wake_host_o <= 1'b0;
        end
        else if (clk_en)
        begin
            wake_host_o <= 1'b0;
        end
    end

    // Wake pull is enabled only while active, so an off card never loads the line.
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            wake_host_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            wake_host_oe <= going_active && wake_request;
        end
    end

    // Open-drain LED pin only ever sinks current, so its data stays zero.
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            status_led_drive_n_o <= 1'b0;
        end
        else if (clk_en)
        begin
            status_led_drive_n_o <= 1'b0;
        end
    end

    // LED lights while active and asked for; it goes dark when the card is off.
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            status_led_drive_n_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            status_led_drive_n_oe <= going_active && led_on_request;
        end
    end
endmodule : mprs_sequencer
`default_nettype wire
